// ### hdl/osm_core.sv
// output alignment group control, pin or software trigger, unlock silencing,
// frame-reference replica to pins and per-output driver format control
// assumes clk is the shared pll output clock; pin inputs are asynchronous
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [R1] group dividers leave reset on same cycle
// [R2] group membership needs four enables, frame-ref one only when in use
// [R3] trigger from mode-31 pin or software bit
// [R4] asserted: hold enabled dividers, outputs low
// [R5] release common-pll outputs phase aligned
// [R6] non-enabled channels ignore alignment events
// [R7] outputs from held post-divider are invalid
// [R8] non-enabled post-dividers keep running
// [R9] bypass dividers never gated by alignment
// [R10] pin polarity decode; software high asserts
// [R11] mute enabled output when source invalid
// [R12] mute disabled output never silenced on unlock
// [R13] auto-mute start glitchless after lock
// [R14] replica needs pin enable and source
// [R15] replica tapped after static delay
// [R16] replica is continuous, never pulsed
// [R17] cmos legs: normal, invert, hiz, low
// [R18] cmos format only on channels 0, 1
// [R19] per-output format; off saves power
// [R20] held alignment keeps outputs low
// [R21] divider powered down when drivers off
// [R22] trigger ored and pin synchronised
// [R23] silence enters and leaves at clock low
module osm_core
    import osm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [NUM_PIN-1:0]     pin_in,
    input  wire logic [NUM_PIN*5-1:0]   pin_function_select,
    input  wire logic [NUM_PIN-1:0]     pin_polarity_invert,
    input  wire logic [NUM_PIN-1:0]     pin_output_enable,
    input  wire logic                   software_align_trigger,
    input  wire logic                   global_align_enable,
    input  wire logic [NUM_CH-1:0]      divider_align_enable,
    input  wire logic [NUM_CH-1:0]      frame_ref_divider_align_enable,
    input  wire logic [NUM_CH-1:0]      frame_ref_in_use,
    input  wire logic [NUM_CH*2-1:0]    channel_source_select,
    input  wire logic [NUM_PD-1:0]      post_divider_align_enable,
    input  wire logic [NUM_CH*12-1:0]   divider_value,
    input  wire logic [NUM_CH-1:0]      mute_enable,
    input  wire logic [NUM_PD-1:0]      silence_on_analog_loop_unlock,
    input  wire logic [NUM_PD-1:0]      silence_on_digital_loop_unlock,
    input  wire logic [NUM_PD-1:0]      silence_on_digital_phase_unlock,
    input  wire logic [NUM_PD-1:0]      analog_lock,
    input  wire logic [NUM_PD-1:0]      digital_lock,
    input  wire logic [NUM_PD-1:0]      digital_phase_lock,
    input  wire logic [NUM_CH-1:0]      channel_clock,
    input  wire logic [NUM_CH-1:0]      static_delay_frame_ref,
    input  wire logic [NUM_CH-1:0]      frame_ref_pin_replica_enable,
    input  wire logic [NUM_CH*6-1:0]    output_format,
    input  wire logic [7:0]             cmos_leg_mode,
    output logic                        align_active,
    output logic [NUM_PD-1:0]           post_divider_reset,
    output logic [NUM_CH-1:0]           divider_reset,
    output logic [NUM_CH-1:0]           divider_power_down,
    output logic [NUM_CH*2-1:0]         driver_enable,
    output logic [NUM_CH*2-1:0]         driver_data,
    output logic [3:0]                  cmos_leg_out,
    output logic [3:0]                  cmos_leg_oe,
    output logic [NUM_PIN-1:0]          pin_out,
    output logic [NUM_PIN-1:0]          pin_oe
);

    logic [NUM_PIN-1:0] pin_meta;
    logic [NUM_PIN-1:0] pin_sync;
    logic [NUM_PIN-1:0] pin_hit;
    logic               align_req;
    osm_state_e         state;
    osm_state_e         next_state;
    logic [NUM_PD-1:0]  pd_invalid;
    logic [NUM_CH-1:0]  member;
    logic [NUM_CH-1:0]  hold;
    logic [NUM_CH-1:0]  src_held;
    logic [NUM_CH-1:0]  silence;
    logic [NUM_CH-1:0]  gate;
    logic [NUM_CH-1:0]  clk_d;
    logic [NUM_CH-1:0]  fmt_on;
    logic               replica_src;
    logic               replica_q;
    logic [1:0]         cmos_on;

    // [R22] two-stage pin synchroniser
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PIN; g++)
        begin : g_pin
            // [R10] polarity decode of the pin level
            assign pin_hit[g] = (pin_function_select[g*5 +: 5] == PIN_MODE_ALIGN)
                                && (pin_sync[g] ^ pin_polarity_invert[g]);
        end
    endgenerate

    // [R3] pin or software trigger
    assign align_req = (|pin_hit) | software_align_trigger;

    // [R20] hold lasts as long as the trigger does
    always_comb
    begin
        next_state = state;
        unique case (state)
            OSM_RUN:  if (align_req) next_state = OSM_HOLD;
            OSM_HOLD: if (!align_req) next_state = OSM_REL;
            OSM_REL:  next_state = align_req ? OSM_HOLD : OSM_RUN;
            default:  next_state = OSM_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= OSM_RUN;
        else
            state <= next_state;
    end

    assign align_active = (state == OSM_HOLD);

    // [R8] only align-enabled post-dividers are held
    assign post_divider_reset = align_active && global_align_enable
                                ? post_divider_align_enable : '0;

    generate
        for (g = 0; g < NUM_PD; g++)
        begin : g_pd
            // [R11] unlock sources by their silence controls
            assign pd_invalid[g] = (silence_on_analog_loop_unlock[g] & ~analog_lock[g])
                                 | (silence_on_digital_loop_unlock[g] & ~digital_lock[g])
                                 | (silence_on_digital_phase_unlock[g]
                                    & ~digital_phase_lock[g]);
        end
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            logic [1:0] src;
            logic [2:0] fa;
            logic [2:0] fb;
            assign src = channel_source_select[g*2 +: 2];
            assign fa  = output_format[g*6 +: 3];
            assign fb  = output_format[g*6+3 +: 3];
            // [R2] four enables to join the group; frame-ref one only when in use
            assign member[g] = divider_align_enable[g] && global_align_enable
                && post_divider_align_enable[src]
                && (!frame_ref_in_use[g] || frame_ref_divider_align_enable[g]);
            // [R6] [R9] unaligned or bypass channels untouched
            assign hold[g] = align_active && member[g]
                             && (divider_value[g*12 +: 12] != DIV_BYPASS);
            // [R7] held post-divider makes the source invalid
            assign src_held[g] = post_divider_reset[src];
            // [R12] [R13] unlock silence only when mute enabled
            assign silence[g] = hold[g] || src_held[g]
                                || (mute_enable[g] && pd_invalid[src]);
            // [R19] [R18] format off, cmos only on 0 and 1
            // channels 0 and 1 have one driver; cmos asked of a wide bank counts as off
            assign driver_enable[g*2 +: 2] = {g >= 2 && fb != FMT_OFF && fb != FMT_CMOS,
                                              fa != FMT_OFF && (g < 2 || fa != FMT_CMOS)};
            assign fmt_on[g] = |driver_enable[g*2 +: 2];
            // [R21] divider powered down with its drivers
            assign divider_power_down[g] = !fmt_on[g];
        end
    endgenerate

    // [R1] [R5] one shared edge drives every group reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            divider_reset <= '0;
        else
            divider_reset <= hold;
    end

    // [R23] gate changes only while the clock is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gate  <= '1;
            clk_d <= '0;
        end
        else
        begin
            clk_d <= channel_clock;
            for (int i = 0; i < NUM_CH; i++)
                if (!channel_clock[i])
                    gate[i] <= silence[i];
        end
    end

    // [R4] held or muted outputs forced low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            driver_data <= '0;
        else
            for (int i = 0; i < NUM_CH; i++)
                driver_data[i*2 +: 2] <= {2{clk_d[i] & ~gate[i]}};
    end

    // [R18] legs exist only while a low channel is in cmos format
    assign cmos_on = {output_format[8:6] == FMT_CMOS, output_format[2:0] == FMT_CMOS};

    // [R17] per-leg follow, invert, release or static low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmos_leg_out <= '0;
            cmos_leg_oe  <= '0;
        end
        else
            for (int i = 0; i < 4; i++)
            begin
                cmos_leg_oe[i] <= cmos_on[i/2] && (cmos_leg_mode[i*2 +: 2] != SE_HIZ);
                // a silenced leg sits low even when inverted, like the differential pair
                unique case (cmos_leg_mode[i*2 +: 2])
                    SE_NORMAL: cmos_leg_out[i] <= cmos_on[i/2] & clk_d[i/2] & ~gate[i/2];
                    SE_INVERT: cmos_leg_out[i] <= cmos_on[i/2] & ~clk_d[i/2] & ~gate[i/2];
                    SE_HIZ,
                    SE_LOW:    cmos_leg_out[i] <= 1'b0;
                endcase
            end
    end

    // [R14] [R15] [R16] continuous replica from static-delay tap
    assign replica_src = |(frame_ref_pin_replica_enable & frame_ref_in_use
                           & static_delay_frame_ref);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            replica_q <= 1'b0;
            pin_out   <= '0;
            pin_oe    <= '0;
        end
        else
        begin
            replica_q <= replica_src;
            pin_out   <= {NUM_PIN{replica_q}} & pin_output_enable;
            pin_oe    <= pin_output_enable
                         & {NUM_PIN{|(frame_ref_pin_replica_enable & frame_ref_in_use)}};
        end
    end

    // [R4] group dividers held while aligning
    property p_hold_reset;
        @(posedge clk) disable iff (rst)
        hold[0] |=> divider_reset[0];
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("held divider not reset"); // [R4]

    // [R1] whole group leaves reset on one edge
    property p_group_release;
        @(posedge clk) disable iff (rst)
        $fell(align_active) |=> (divider_reset == '0);
    endproperty
    a_group_release: assert property (p_group_release) // [R1]
        else $error("group release not simultaneous");

    // [R9] bypass divider never held
    property p_bypass_free;
        @(posedge clk) disable iff (rst)
        (divider_value[11:0] == DIV_BYPASS) |=> !divider_reset[0];
    endproperty
    a_bypass_free: assert property (p_bypass_free) // [R9]
        else $error("bypass divider held");

    // [R6] unaligned channel never held
    property p_unaligned_free;
        @(posedge clk) disable iff (rst)
        !divider_align_enable[0] |=> !divider_reset[0];
    endproperty
    a_unaligned_free: assert property (p_unaligned_free) // [R6]
        else $error("unaligned divider held");

    // [R20] hold needs a standing trigger
    property p_hold_needs_request;
        @(posedge clk) disable iff (rst)
        !align_req |=> !align_active;
    endproperty
    a_hold_needs_request: assert property (p_hold_needs_request) // [R20]
        else $error("hold without trigger");

    // [R23] gate moves only after a low clock
    property p_gate_at_low;
        @(posedge clk) disable iff (rst)
        $changed(gate[0]) |-> !$past(channel_clock[0]);
    endproperty
    a_gate_at_low: assert property (p_gate_at_low) // [R23]
        else $error("gate moved while clock high");

endmodule : osm_core

`default_nettype wire

// ### hdl/osm_pkg.sv
// package for the output alignment and silence controller
// assumes one core clock standing in for the shared pll output clock
package osm_pkg;
    localparam int          NUM_CH         = 6;
    localparam int          NUM_PD         = 4;
    localparam int          NUM_PIN        = 2;
    localparam logic [4:0]  PIN_MODE_ALIGN = 5'h1F;
    localparam logic [11:0] DIV_BYPASS     = 12'h001;
    localparam logic [11:0] DIV_RESET      = 12'h000;
    localparam logic [1:0]  SE_NORMAL      = 2'h0;
    localparam logic [1:0]  SE_INVERT      = 2'h1;
    localparam logic [1:0]  SE_HIZ         = 2'h2;
    localparam logic [1:0]  SE_LOW         = 2'h3;
    localparam logic [2:0]  FMT_OFF        = 3'h0;
    localparam logic [2:0]  FMT_CMOS       = 3'h4;
    typedef enum logic [1:0] {
        OSM_RUN  = 2'b00,
        OSM_HOLD = 2'b01,
        OSM_REL  = 2'b11
    } osm_state_e;
endpackage : osm_pkg

// ### sim/osm_clock_source.sv
// far-side model: post-divider clocks and frame-reference taps
// assumes clk is the shared pll output clock
`timescale 1ns/10ps
`default_nettype none
module osm_clock_source
    import osm_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    output logic [NUM_CH-1:0] channel_clock,
    output logic [NUM_CH-1:0] static_delay_frame_ref
);
    logic [2:0] cnt;
    // free-running, so unaligned channels keep toggling
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= 3'h0;
        else
            cnt <= cnt + 3'h1;
    end
    assign channel_clock          = {3{cnt[1:0]}};
    assign static_delay_frame_ref = {NUM_CH{cnt[2]}};
endmodule : osm_clock_source
`default_nettype wire

// ### sim/output_sync_mute_control_tb_top.sv
// bench: random setups, software and pin alignment, format decode
// assumes osm_pkg, osm_core and osm_clock_source compiled first
`timescale 1ns/10ps
`default_nettype none
module output_sync_mute_control_tb_top;
    import osm_pkg::*;
    logic              clk = 0, rst = 1, sw = 0, glb = 0;
    logic [1:0]        pin = 0, pol = 0, oen = 0;
    logic [9:0]        mode = 0;
    logic [5:0]        den = 0, fen = 0, fus = 0, men = 0, rep = 0;
    logic [11:0]       src = 0;
    logic [3:0]        pen = 0, sa = 0, sd = 0, sp = 0, al = 0, dl = 0, pl = 0;
    logic [7:0]        leg = 0;
    logic [71:0]       dval = 0;
    logic [35:0]       fmt = 0;
    logic [5:0]        cclk, fref, drst, pd;
    logic [11:0]       drv, dd;
    logic [3:0]        pdr, lo, loe;
    logic [1:0]        po, poe, fh;
    logic              act;
    logic [31:0]       seed = 32'h5D9A3BE0;
    int                n_errors = 0;
    int                n_checks = 0;
    always #12.5 clk = ~clk;
    // replica path is two registers deep
    always @(posedge clk)
        fh <= {fh[0], fref[0]};
    osm_core DUT
    (
        .clk(clk), .rst(rst), .pin_in(pin), .pin_function_select(mode),
        .pin_polarity_invert(pol), .pin_output_enable(oen), .software_align_trigger(sw),
        .global_align_enable(glb), .divider_align_enable(den),
        .frame_ref_divider_align_enable(fen), .frame_ref_in_use(fus),
        .channel_source_select(src), .post_divider_align_enable(pen), .divider_value(dval),
        .mute_enable(men), .silence_on_analog_loop_unlock(sa),
        .silence_on_digital_loop_unlock(sd), .silence_on_digital_phase_unlock(sp),
        .analog_lock(al), .digital_lock(dl), .digital_phase_lock(pl), .channel_clock(cclk),
        .static_delay_frame_ref(fref), .frame_ref_pin_replica_enable(rep),
        .output_format(fmt), .cmos_leg_mode(leg), .align_active(act),
        .post_divider_reset(pdr), .divider_reset(drst), .divider_power_down(pd),
        .driver_enable(drv), .driver_data(dd), .cmos_leg_out(lo), .cmos_leg_oe(loe),
        .pin_out(po), .pin_oe(poe)
    );
    osm_clock_source u_src
    (
        .clk(clk), .rst(rst), .channel_clock(cclk), .static_delay_frame_ref(fref)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [5:0] grp();
        grp = '0;
        for (int g = 0; g < NUM_CH; g++)
            grp[g] = den[g] & glb & pen[src[g*2+:2]] & (~fus[g] | fen[g])
                     & (dval[g*12+:12] != DIV_BYPASS);
        return grp;
    endfunction : grp
    // channels that must stay low while aligning
    function automatic logic dark(input int g);
        int p;
        p = src[g*2+:2];
        return (glb & pen[p])
               | (men[g] & ((sa[p] & ~al[p]) | (sd[p] & ~dl[p]) | (sp[p] & ~pl[p])));
    endfunction : dark
    // cmos legal on 0 and 1 only, which have one driver
    function automatic logic [1:0] drv_exp(input int g);
        logic [2:0] fa;
        logic [2:0] fb;
        logic [1:0] e;
        fa = fmt[g*6+:3];
        fb = fmt[g*6+3+:3];
        e[0] = fa != FMT_OFF && (g < 2 || fa != FMT_CMOS);
        e[1] = g >= 2 && fb != FMT_OFF && fb != FMT_CMOS;
        return e;
    endfunction : drv_exp
    // a leg toggles only when cmos, clocked and not dark
    function automatic logic leg_live(input int i);
        logic [1:0] m;
        m = leg[i*2+:2];
        return fmt[(i/2)*6+:3] == FMT_CMOS && !dark(i/2)
               && (m == SE_NORMAL || m == SE_INVERT);
    endfunction : leg_live
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    // pin 0 starts idle: level equals its polarity bit
    task shuffle();
        logic [31:0] r;
        logic [31:0] q;
        r = rnd();
        q = rnd();
        {den, fen, fus, men, rep} <= r[29:0];
        {pen, sa, sd, sp, al, dl, pl} <= q[27:0];
        r = rnd();
        src <= r[11:0];
        glb <= r[12] | r[13];
        oen <= {r[14], 1'b0};
        pol <= r[16:15];
        pin <= r[16:15];
        leg <= r[24:17];
        mode <= {5'h00, PIN_MODE_ALIGN};
        r = rnd();
        q = rnd();
        fmt <= {r[3:0], q};
        for (int g = 0; g < NUM_CH; g++)
            dval[g*12+:12] <= r[24+g] ? DIV_BYPASS : 12'h004;
    endtask : shuffle
    initial
    begin
        logic [11:0] acc;
        logic [3:0]  acc_leg;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int t = 0; t < 32; t++)
        begin
            @(posedge clk);
            shuffle();
            // a polarity flip can fake one short pin event; let it pass first
            repeat (6) @(negedge clk);
            check(drst, '0);
            check(pdr, '0);
            check(poe, oen & {2{|(rep & fus)}});
            check(po, oen & {2{|(rep & fus) & fh[1]}});
            for (int g = 0; g < NUM_CH; g++)
            begin
                check(drv[g*2+:2], drv_exp(g));
                check(pd[g], drv_exp(g) == 2'b00);
            end
            for (int i = 0; i < 4; i++)
                check(loe[i], fmt[(i/2)*6+:3] == FMT_CMOS && leg[i*2+:2] != SE_HIZ);
            @(posedge clk);
            if (t[0])
                sw <= 1'b1;
            else
                pin[0] <= ~pol[0];
            for (int i = 0; i < 8 && act !== 1'b1; i++)
                @(negedge clk);
            check(act, 1'b1);
            if (act !== 1'b1)
                test_done();
            repeat (2) @(negedge clk);
            check(drst, grp());
            check(pdr, glb ? pen : 4'h0);
            // gates move on a low clock phase, so give them time to land
            repeat (2) @(negedge clk);
            acc = '0;
            acc_leg = '0;
            repeat (4)
            begin
                @(negedge clk);
                acc |= dd;
                acc_leg |= lo;
            end
            for (int g = 0; g < NUM_CH; g++)
                check(|acc[g*2+:2], !dark(g));
            for (int i = 0; i < 4; i++)
                check(acc_leg[i], leg_live(i));
            @(posedge clk);
            sw <= 1'b0;
            pin[0] <= pol[0];
            for (int k = 0; k < 6; k++)
            begin
                @(negedge clk);
                check(drst == grp() || drst == 6'h00, 1'b1);
            end
            check(act, 1'b0);
            check(drst, '0);
        end
        test_done();
    end
endmodule : output_sync_mute_control_tb_top
`default_nettype wire
